/* rtl/strobe_ctl.v */
// Notes on behaviour
// - Line load strobe fires low at T14 when move-acc-to-line decoded.
// - Cursor load: upper six bits to line, lower six to character.
// - Cursor transfer enable in execute-B on addressed+select, or load-cursor.
// - Cursor transfer strobes line and character only at T14.
// - Reset strobes both; clear/move ops strobe line or character alone.
// - Data register captures data bus at T4 unless waiting idle.
// - Low insert control from console suppresses memory capture.
// - Acc-to-data enable: bypass high and store in execute-A or boot done.
// - Byte strobe loads accumulator into half word at T9.
// - Aux-to-data enable: bypass high and store-cursor in execute-A.
// - Low field and upper field strobed separately; low field also on request.
// - Address bus from aux unit unless special path takes over.
// - Interrupt entry places FF8 on address bus.
// - Ext D gates controller save address.
// - Unacknowledged I/O gates controller save address.
// - Power restart forces address register to FFC.
// - Address register strobed each T19 except while idle waiting.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "strobe_ctl_regs.vh"
module strobe_ctl #(
	parameter PHASES = 20
) (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Avalon-MM slave
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Datapath inputs
	input wire [15:0] mem_data_bus,
	input wire [7:0] accumulator_reg,
	input wire [11:0] aux_arith_bus,
	// Strobes and enables
	output wire line_load_strobe,
	output wire char_load_strobe,
	output wire cursor_xfer_enable,
	output wire acc_to_mdata_enable,
	output wire aux_to_mdata_enable,
	output wire byte_write_strobe,
	output wire low_field_capture_strobe,
	output wire memory_capture_strobe,
	output wire mar_strobe,
	output wire special_addr_gate,
	// Registers seen by the datapath
	output reg [5:0] cursor_line_reg,
	output reg [5:0] cursor_char_reg,
	output reg [15:0] mem_data_reg,
	output reg [11:0] mem_addr_reg,
	output reg [11:0] mem_addr_bus,
	output wire [4:0] phase
);
	reg [31:0] ctl_r;
	reg [31:0] opc_r;
	reg [9:0] strobe_cnt_r;
	reg ack_r;
	wire [4:0] phase_w;
	wire t4, t9, t14, t19;
	wire op_move_acc_to_line, op_load_cursor, op_clear_line, op_clear_char;
	wire op_move_acc_to_cursor, op_store, op_store_cursor;
	wire wait_idle, insert_n, exec_a, exec_b, bypass, boot_char_done_n;
	wire cursor_addressed, cursor_select_cond, low_field_clock_req_n, register_reset_n;
	wire cur_xfer, acc_en, aux_en, sp_gate;
	wire [11:0] sp_addr;

	phase_gen #(.PHASES(PHASES)) u_phase (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.run(ctl_r[`CTL_RUN]),
		.phase_r(phase_w)
	);
	assign phase = phase_w;

	// One-phase-wide pulses
	assign t4 = (phase_w == `PH_MDR_CAPTURE);
	assign t9 = (phase_w == `PH_BYTE);
	assign t14 = (phase_w == `PH_CURSOR);
	assign t19 = (phase_w == `PH_MAR);

	assign op_move_acc_to_line = opc_r[`OPC_MOVE_LINE];
	assign op_load_cursor = opc_r[`OPC_LOAD_CUR];
	assign op_clear_line = opc_r[`OPC_CLR_LINE];
	assign op_clear_char = opc_r[`OPC_CLR_CHAR];
	assign op_move_acc_to_cursor = opc_r[`OPC_MOVE_CUR];
	assign op_store = opc_r[`OPC_STORE];
	assign op_store_cursor = opc_r[`OPC_STORE_CUR];
	assign wait_idle = ctl_r[`CTL_WAIT];
	assign insert_n = ctl_r[`CTL_INSERT_N];
	assign exec_a = ctl_r[`CTL_EXEC_A];
	assign exec_b = ctl_r[`CTL_EXEC_B];
	assign bypass = ctl_r[`CTL_BYPASS];
	assign boot_char_done_n = ctl_r[`CTL_BOOT_DONE_N];
	assign cursor_addressed = ctl_r[`CTL_CUR_ADDR];
	assign cursor_select_cond = ctl_r[`CTL_CUR_SEL];
	assign low_field_clock_req_n = ctl_r[`CTL_LOWCLK_N];
	assign register_reset_n = ctl_r[`CTL_REG_RESET_N];

	// Cursor transfer
	assign cur_xfer = exec_b && ((cursor_addressed && cursor_select_cond) || !op_load_cursor);
	assign cursor_xfer_enable = ~cur_xfer;
	assign line_load_strobe = ~(t14 && (cur_xfer || !register_reset_n
		|| !op_clear_line || !op_move_acc_to_line));
	assign char_load_strobe = ~(t14 && (cur_xfer || !register_reset_n
		|| !op_clear_char || !op_move_acc_to_cursor));

	// Memory data register
	assign memory_capture_strobe = t4 && !wait_idle && insert_n;
	assign acc_en = bypass && ((!op_store && exec_a) || !boot_char_done_n);
	assign acc_to_mdata_enable = ~acc_en;
	assign byte_write_strobe = acc_en && t9;
	assign aux_en = bypass && !op_store_cursor && exec_a;
	assign aux_to_mdata_enable = ~aux_en;
	assign low_field_capture_strobe = memory_capture_strobe || (t9 && !low_field_clock_req_n);

	// Address path
	assign mar_strobe = t19 && !wait_idle;
	special_addr u_spaddr (
		.instr_done(ctl_r[`CTL_INSTR_DONE]),
		.last_ext(ctl_r[`CTL_LAST_EXT]),
		.irq_pend(ctl_r[`CTL_IRQ_PEND]),
		.ext_d(ctl_r[`CTL_EXT_D]),
		.io_nack_n(ctl_r[`CTL_IO_NACK_N]),
		.pwr_restart(ctl_r[`CTL_PWR_RESTART]),
		.dev_num(ctl_r[`CTL_DEV_LSB+3:`CTL_DEV_LSB]),
		.gate(sp_gate),
		.addr(sp_addr)
	);
	assign special_addr_gate = sp_gate;

	always @* begin
		if (sp_gate)
			mem_addr_bus = sp_addr;
		else
			mem_addr_bus = aux_arith_bus;
	end

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cursor_line_reg <= 6'h00;
			cursor_char_reg <= 6'h00;
			mem_data_reg <= 16'h0000;
			mem_addr_reg <= 12'h000;
			strobe_cnt_r <= 10'h000;
		end else begin
			if (!line_load_strobe)
				cursor_line_reg <= (!register_reset_n || !op_clear_line) ? 6'h00
					: (cur_xfer ? aux_arith_bus[11:6] : accumulator_reg[5:0]);
			if (!char_load_strobe)
				cursor_char_reg <= (!register_reset_n || !op_clear_char) ? 6'h00
					: (cur_xfer ? aux_arith_bus[5:0] : accumulator_reg[5:0]);
			if (memory_capture_strobe)
				mem_data_reg[15:12] <= mem_data_bus[15:12];
			if (byte_write_strobe)
				mem_data_reg[7:0] <= accumulator_reg;
			else if (low_field_capture_strobe)
				mem_data_reg[11:0] <= aux_en ? aux_arith_bus : mem_data_bus[11:0];
			if (mar_strobe)
				mem_addr_reg <= mem_addr_bus;
			if (mar_strobe || byte_write_strobe)
				strobe_cnt_r <= strobe_cnt_r + 10'h001;
		end
	end

	// Avalon slave: one wait state on every access
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			ctl_r <= `CTL_RESET;
			opc_r <= `OPC_RESET;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
			if (avs_write && !ack_r) begin
				case (avs_address)
				`OFS_CONTROL: ctl_r <= avs_writedata;
				`OFS_OPCODES: opc_r <= avs_writedata;
				default: ;
				endcase
			end
			if (avs_read && !ack_r) begin
				case (avs_address)
				`OFS_CONTROL: avs_readdata <= ctl_r;
				`OFS_OPCODES: avs_readdata <= opc_r;
				`OFS_STATUS: avs_readdata <= {16'h0000, sp_gate, cur_xfer, acc_en, aux_en, strobe_cnt_r, phase_w[1:0]};
				`OFS_CURSOR: avs_readdata <= {20'h0_0000, cursor_line_reg, cursor_char_reg};
				`OFS_MDATA: avs_readdata <= {16'h0000, mem_data_reg};
				`OFS_ADDR: avs_readdata <= {20'h0_0000, mem_addr_reg};
				`OFS_STROBES: avs_readdata <= {27'h000_0000, phase_w};
				default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // strobe_ctl

/* rtl/strobe_ctl_regs.vh */
`ifndef STROBE_CTL_REGS_VH
`define STROBE_CTL_REGS_VH

// Register offsets (byte addresses, one word each)
`define OFS_CONTROL 8'h00
`define OFS_OPCODES 8'h04
`define OFS_STATUS 8'h08
`define OFS_CURSOR 8'h0C
`define OFS_MDATA 8'h10
`define OFS_ADDR 8'h14
`define OFS_STROBES 8'h18

// Control register fields
`define CTL_RUN 0
`define CTL_WAIT 1
`define CTL_INSERT_N 2
`define CTL_EXEC_A 3
`define CTL_EXEC_B 4
`define CTL_BYPASS 5
`define CTL_BOOT_DONE_N 6
`define CTL_CUR_ADDR 7
`define CTL_CUR_SEL 8
`define CTL_INSTR_DONE 9
`define CTL_LAST_EXT 10
`define CTL_IRQ_PEND 11
`define CTL_EXT_D 12
`define CTL_IO_NACK_N 13
`define CTL_PWR_RESTART 14
`define CTL_LOWCLK_N 15
`define CTL_REG_RESET_N 16
`define CTL_DEV_LSB 20
`define CTL_RESET 32'h0001_E044

// Opcode decode register fields (each active low)
`define OPC_MOVE_LINE 0
`define OPC_LOAD_CUR 1
`define OPC_CLR_LINE 2
`define OPC_CLR_CHAR 3
`define OPC_MOVE_CUR 4
`define OPC_STORE 5
`define OPC_STORE_CUR 6
`define OPC_RESET 32'h0000_007F

// Special addresses
`define ADDR_IRQ_SAVE 12'hFF8
`define ADDR_PC_STEP 12'h002
`define ADDR_RESTART 12'hFFC
`define ADDR_CTRL_BASE 12'hFE0
`define ADDR_MDATA_MASK 16'h0FFF

// Phase timing
`define PHASE_COUNT 5'd20
`define PH_MDR_CAPTURE 5'd4
`define PH_BYTE 5'd9
`define PH_CURSOR 5'd14
`define PH_MAR 5'd19

`endif

/* rtl/phase_gen.v */
`timescale 1ns/1ps
module phase_gen #(
	parameter PHASES = 20
) (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	input wire run,
	// Phase number 1..PHASES, 0 while stopped
	output reg [4:0] phase_r
);
	localparam [4:0] LAST_PHASE = PHASES;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			phase_r <= 5'h00;
		else if (!run)
			phase_r <= 5'h00;
		else if (phase_r == LAST_PHASE || phase_r == 5'h00)
			phase_r <= 5'h01;
		else
			phase_r <= phase_r + 5'h01;
	end
endmodule // phase_gen

/* rtl/special_addr.v */
`timescale 1ns/1ps
`include "strobe_ctl_regs.vh"
module special_addr (
	// Conditions
	input wire instr_done,
	input wire last_ext,
	input wire irq_pend,
	input wire ext_d,
	input wire io_nack_n,
	input wire pwr_restart,
	input wire [3:0] dev_num,
	// Result
	output reg gate,
	output reg [11:0] addr
);
	wire [11:0] ctrl_addr;
	// Each controller owns a four-byte save slot from the base; numbers 8 to 15 wrap to 000 to 01C
	assign ctrl_addr = `ADDR_CTRL_BASE + {6'h00, dev_num[3:0], 2'b00};
	always @* begin
		gate = 1'b0;
		addr = 12'h000;
		if (pwr_restart) begin
			gate = 1'b1;
			addr = `ADDR_RESTART;
		end else if (ext_d || !io_nack_n) begin
			gate = 1'b1;
			addr = ctrl_addr;
		end else if (instr_done && !last_ext && irq_pend) begin
			gate = 1'b1;
			addr = `ADDR_IRQ_SAVE;
		end
	end
endmodule // special_addr

/* verif/strobe_ctl_props.sv */
`timescale 1ns/1ps
module strobe_ctl_props (
	// Clock and reset
	input wire sys_clk,
	input wire rstn,
	// Watched ports
	input wire [15:0] mem_data_bus,
	input wire [11:0] aux_arith_bus,
	input wire line_load_strobe,
	input wire aux_to_mdata_enable,
	input wire acc_to_mdata_enable,
	input wire byte_write_strobe,
	input wire low_field_capture_strobe,
	input wire memory_capture_strobe,
	input wire mar_strobe,
	input wire special_addr_gate,
	input wire [15:0] mem_data_reg,
	input wire [11:0] mem_addr_reg,
	input wire [11:0] mem_addr_bus,
	input wire [4:0] phase
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_wrap;
		phase == 5'd1 || phase == 5'd0;
	endsequence
	chk_line_time: assert property (!line_load_strobe |-> phase == 5'd14)
		else $error("line strobe off its phase");
	chk_cap_time: assert property (memory_capture_strobe |-> phase == 5'd4)
		else $error("capture strobe off its phase");
	chk_cap_data: assert property (memory_capture_strobe && aux_to_mdata_enable |=> mem_data_reg == $past(mem_data_bus))
		else $error("data register missed the bus");
	chk_byte_time: assert property (byte_write_strobe |-> phase == 5'd9 && !acc_to_mdata_enable)
		else $error("byte strobe without enable");
	chk_low_field: assert property (low_field_capture_strobe |-> memory_capture_strobe || phase == 5'd9)
		else $error("low field strobe stray");
	chk_mar_time: assert property (mar_strobe |-> phase == 5'd19)
		else $error("address strobe off its phase");
	chk_mar_load: assert property (mar_strobe |=> mem_addr_reg == $past(mem_addr_bus))
		else $error("address register missed the bus");
	chk_phase_wrap: assert property (phase == 5'd20 |=> s_wrap)
		else $error("phase did not wrap");
	chk_gate_high: assert property (special_addr_gate |-> mem_addr_bus[11:5] == 7'h7F)
		else $error("special address out of range");
	chk_gate_low: assert property (!special_addr_gate |-> mem_addr_bus == aux_arith_bus)
		else $error("bus not from aux unit");
endmodule // strobe_ctl_props
bind strobe_ctl strobe_ctl_props chk (.sys_clk(sys_clk), .rstn(rstn), .mem_data_bus(mem_data_bus),
	.aux_arith_bus(aux_arith_bus), .line_load_strobe(line_load_strobe), .aux_to_mdata_enable(aux_to_mdata_enable),
	.acc_to_mdata_enable(acc_to_mdata_enable), .byte_write_strobe(byte_write_strobe),
	.low_field_capture_strobe(low_field_capture_strobe), .memory_capture_strobe(memory_capture_strobe),
	.mar_strobe(mar_strobe), .special_addr_gate(special_addr_gate), .mem_data_reg(mem_data_reg),
	.mem_addr_reg(mem_addr_reg), .mem_addr_bus(mem_addr_bus), .phase(phase));

/* verif/datapath_model.sv */
`timescale 1ns/1ps
module datapath_model (
	// Timing
	input wire sys_clk,
	input wire rstn,
	input wire memory_capture_strobe,
	// Datapath values
	output wire [15:0] mem_data_bus,
	output wire [7:0] accumulator_reg,
	output wire [11:0] aux_arith_bus
);
	reg [15:0] junk_r;
	// Memory drives C3A5 only while the capture strobe is high, and a changing junk word otherwise
	assign mem_data_bus = memory_capture_strobe ? 16'hC3A5 : junk_r;
	assign accumulator_reg = 8'h3B;
	assign aux_arith_bus = 12'hA5C;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			junk_r <= 16'h0000;
		end else begin
			junk_r <= junk_r + 16'h1357;
		end
	end
endmodule // datapath_model

/* verif/strobe_ctl_tb.sv */
`timescale 1ns/1ps
module strobe_ctl_tb;
	reg sys_clk, rstn, avs_read, avs_write;
	reg [7:0] avs_address;
	reg [31:0] avs_writedata, rd;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, line_load_strobe, char_load_strobe, cursor_xfer_enable, acc_to_mdata_enable;
	wire aux_to_mdata_enable, byte_write_strobe, low_field_capture_strobe, memory_capture_strobe;
	wire mar_strobe, special_addr_gate;
	wire [15:0] mem_data_bus, mem_data_reg;
	wire [7:0] accumulator_reg;
	wire [11:0] aux_arith_bus, mem_addr_reg, mem_addr_bus;
	wire [5:0] cursor_line_reg, cursor_char_reg;
	wire [4:0] phase;
	integer fails, n_tests, i;
	logic [31:0] cv [0:2] = '{32'h0001_A045, 32'h0001_A041, 32'h0001_A047};
	logic [9:0] cop [0:3] = '{{3'd4, 1'b0, 6'h3B}, {3'd3, 1'b0, 6'h00}, {3'd0, 1'b1, 6'h3B}, {3'd2, 1'b1, 6'h00}};
	logic [44:0] sa [0:4] = '{{1'b1, 12'hFF8, 32'h0001_AA45}, {1'b0, 12'hA5C, 32'h0001_AE45},
		{1'b1, 12'hFE8, 32'h0021_B045}, {1'b1, 12'hFE8, 32'h0021_8045}, {1'b1, 12'hFFC, 32'h0001_E045}};
	strobe_ctl dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_data_bus(mem_data_bus), .accumulator_reg(accumulator_reg),
		.aux_arith_bus(aux_arith_bus), .line_load_strobe(line_load_strobe), .char_load_strobe(char_load_strobe),
		.cursor_xfer_enable(cursor_xfer_enable), .acc_to_mdata_enable(acc_to_mdata_enable),
		.aux_to_mdata_enable(aux_to_mdata_enable), .byte_write_strobe(byte_write_strobe),
		.low_field_capture_strobe(low_field_capture_strobe), .memory_capture_strobe(memory_capture_strobe),
		.mar_strobe(mar_strobe), .special_addr_gate(special_addr_gate), .cursor_line_reg(cursor_line_reg),
		.cursor_char_reg(cursor_char_reg), .mem_data_reg(mem_data_reg), .mem_addr_reg(mem_addr_reg),
		.mem_addr_bus(mem_addr_bus), .phase(phase));
	datapath_model partner (.sys_clk(sys_clk), .rstn(rstn), .memory_capture_strobe(memory_capture_strobe),
		.mem_data_bus(mem_data_bus), .accumulator_reg(accumulator_reg), .aux_arith_bus(aux_arith_bus));
	task bus(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			@(posedge sys_clk);
			while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
			rd = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
		end
	endtask
	task chk(input [31:0] e, input [31:0] g, input [63:0] nm);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("unexpected %0s: expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// Sample between edges so strobes and registers have settled
	task at_ph(input [4:0] p);
		begin
			@(negedge sys_clk);
			while (phase !== p) @(negedge sys_clk);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		fails = fails + 1;
		test_done;
	end
	initial begin
		{rstn, avs_read, avs_write, avs_address, avs_writedata} = 0;
		fails = 0;
		n_tests = 0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		bus(0, 8'h00, 0);
		chk(32'h0001_E044, rd, "ctl");
		bus(0, 8'h04, 0);
		chk(32'h0000_007F, rd, "opc");
		bus(0, 8'h40, 0);
		chk(0, rd, "unmapped");
		chk(12'hFFC, mem_addr_bus, "restart");
		$display("test reset done");
		for (i = 0; i < 3; i++) begin
			bus(1, 8'h00, cv[i]);
			at_ph(4);
			chk(i == 0, memory_capture_strobe, "capture");
			at_ph(5);
			chk(16'hC3A5, mem_data_reg, "mdata");
			at_ph(19);
			chk(i != 2, mar_strobe, "marstb");
		end
		chk(12'hA5C, mem_addr_bus, "auxpath");
		$display("test capture done");
		for (i = 0; i < 4; i++) begin
			bus(1, 8'h04, 32'h7F & ~(32'h1 << cop[i][9:7]));
			at_ph(14);
			chk(!cop[i][6], line_load_strobe, "linestb");
			chk(cop[i][6], char_load_strobe, "charstb");
			at_ph(15);
			chk(cop[i][5:0], cop[i][6] ? cursor_line_reg : cursor_char_reg, "cursor");
		end
		bus(1, 8'h00, 32'h0001_A0D5);
		chk(1, cursor_xfer_enable, "xferoff");
		bus(1, 8'h00, 32'h0001_A1D5);
		chk(0, cursor_xfer_enable, "xferon");
		bus(1, 8'h04, 32'h7D);
		bus(1, 8'h00, 32'h0001_A055);
		chk(0, cursor_xfer_enable, "xferop");
		at_ph(14);
		chk(0, line_load_strobe | char_load_strobe, "xferstb");
		at_ph(15);
		chk(12'hA5C, {cursor_line_reg, cursor_char_reg}, "xferval");
		// Register reset line low clears both halves of the cursor
		bus(1, 8'h04, 32'h7F);
		bus(1, 8'h00, 32'h0000_A045);
		at_ph(14);
		chk(0, line_load_strobe | char_load_strobe, "rststb");
		at_ph(15);
		chk(0, {cursor_line_reg, cursor_char_reg}, "regrst");
		$display("test cursor done");
		bus(1, 8'h04, 32'h5F);
		bus(1, 8'h00, 32'h0001_A06D);
		chk(0, acc_to_mdata_enable, "accen");
		at_ph(9);
		chk(1, byte_write_strobe, "bytestb");
		at_ph(10);
		chk(8'h3B, mem_data_reg[7:0], "byte");
		bus(1, 8'h04, 32'h3F);
		bus(1, 8'h00, 32'h0001_206D);
		chk(0, aux_to_mdata_enable, "auxen");
		at_ph(9);
		chk(1, low_field_capture_strobe, "lowstb");
		chk(0, byte_write_strobe, "nobyte");
		at_ph(10);
		chk(16'hCA5C, mem_data_reg, "lowfld");
		bus(1, 8'h04, 32'h7F);
		$display("test store done");
		for (i = 0; i < 5; i++) begin
			bus(1, 8'h00, sa[i][31:0]);
			@(negedge sys_clk);
			chk(sa[i][44], special_addr_gate, "gate");
			chk(sa[i][43:32], mem_addr_bus, "special");
			at_ph(20);
			chk(sa[i][43:32], mem_addr_reg, "mar");
		end
		$display("test address done");
		test_done;
	end
endmodule // strobe_ctl_tb
